// >>> psc_partner.sv
// Model of the system oscillator and of two peripherals that borrow the secondary oscillator.
`timescale 1ns/10ps
module psc_partner (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       osc_on_i,
	input  wire logic [7:0] dly_i,
	input  wire logic [1:0] want_i,
	input  wire logic       sec_rdy_i,
	output logic            osc_ready_o,
	output logic [1:0]      sec_req_o,
	output logic            sec_use_o
);
	logic [7:0] cnt_q;

	////////////////////////////////////////////////////////////////////////////
	// Ready follows power-on after a start delay and drops at once when the oscillator is switched off.
	always_ff @(posedge clk_i) begin
		if (rst_i || !osc_on_i) begin
			cnt_q       <= 8'h00;
			osc_ready_o <= 1'b0;
		end else if (cnt_q < dly_i) begin
			cnt_q <= cnt_q + 8'h01;
		end else begin
			osc_ready_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Each peripheral requests the clock and only uses it once it is ready, however long that takes.
	assign sec_req_o = want_i;
	assign sec_use_o = (|want_i) & sec_rdy_i;
endmodule

// >>> psc_pkg.sv
// Package with the constants, register map and state codes of the power-save controller.
package psc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock rate and timing figures.
	localparam int CLK_HZ               = 200_000_000;
	localparam int CLK_MHZ              = 200;
	localparam int SEC_OSC_START_S      = 1;
	localparam int SEC_OSC_START_CYC    = SEC_OSC_START_S * CLK_HZ;
	localparam int SYS_OSC_SETTLE_NS    = 50;
	localparam int SYS_OSC_SETTLE_CYC   = (SYS_OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the bus.
	localparam logic [3:0] ADR_CTRL     = 4'h0;
	localparam logic [3:0] ADR_OSC_CFG  = 4'h4;
	localparam logic [3:0] ADR_DEV_OPT  = 4'h8;
	localparam logic [3:0] ADR_STATUS   = 4'hc;

	// Field positions.
	localparam int CTRL_MANUAL_BIT      = 0;
	localparam int CTRL_SRC_SEL_LSB     = 4;
	localparam int OSC_CFG_LOCK_BIT     = 0;
	localparam int OSC_CFG_PINSEL_BIT   = 3;
	localparam int DEV_OPT_DRIVE_BIT    = 3;
	localparam int STAT_STATE_LSB       = 0;
	localparam int STAT_OSC_LSB         = 4;
	localparam int STAT_SEC_ON_BIT      = 7;
	localparam int STAT_SEC_RDY_BIT     = 8;
	localparam int STAT_WDT_WAKE_BIT    = 9;

	// Reset values.
	localparam logic [2:0]  SRC_SEL_RST = 3'h0;
	localparam logic        MANUAL_RST  = 1'b0;
	localparam logic        LOCK_RST    = 1'b0;
	localparam logic        PINSEL_RST  = 1'b1;
	localparam logic        DRIVE_RST   = 1'b1;
	localparam logic [23:0] RESET_VECTOR = 24'h000000;

	// Operand of the power-save instruction.
	localparam logic PSAVE_SLEEP        = 1'b0;
	localparam logic PSAVE_IDLE         = 1'b1;

	// Power states.
	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_IDLE  = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_WAKE  = 4'b1000
	} psc_state_t;

endpackage

// >>> psc_sync3.sv
// Three-stage synchroniser that passes a change once the last two stages agree.
`timescale 1ns/10ps
module psc_sync3 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;
	logic out_d;

	// Output only follows when the second and third stages agree.
	always_comb begin
		out_d = (s2_q == s3_q) ? s2_q : out_q;
	end

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q  <= async_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_o = out_q;

endmodule

// >>> psc_top.sv
// Power-state and secondary oscillator controller with a Wishbone register slave.
//
// Operation
// - Any reset returns registers to their reset values, forces the program counter to zero, fetch starts at 0x000000.
// - Reset restarts the core directly, never as a vectored interrupt.
// - A module requesting the secondary oscillator starts it without the manual enable.
// - The manual enable starts the secondary oscillator ahead of any request.
// - Pin select one makes the oscillator usable, zero gives digital pins.
// - Option word bit 3 selects low-drive or high-drive oscillator operation.
// - The power-save instruction enters Sleep or Idle according to its operand.
// - Idle halts the CPU with peripheral clocks on; Sleep stops the system and peripheral clocks.
// - Sleep entry shuts down the system clock source and its oscillator.
// - The clock-failure monitor is off throughout Sleep.
// - The low-power RC clock runs in Sleep when the watchdog is enabled.
// - An enabled watchdog is cleared just before Sleep is entered.
// - System-clock peripherals stop in Sleep; change detect and external-clock ones continue.
// - Sleep or Idle ends on an enabled interrupt, any reset or watchdog time-out.
// - Wake from Sleep resumes with the clock source active at Sleep entry.
// - Writing the new-oscillator field while unlocked requests a clock source switch.
`timescale 1ns/10ps
module psc_top
	import psc_pkg::*;
#(
	parameter int SEC_START_CYC = SEC_OSC_START_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// CPU core side.
	input  wire logic        psave_req_i,
	input  wire logic        psave_mode_i,
	output logic             cpu_restart_o,
	output logic [23:0]      fetch_addr_o,
	output logic             cpu_halt_o,
	output logic             resume_o,
	// Wake sources and watchdog.
	input  wire logic        irq_wake_i,
	input  wire logic        wdt_timeout_i,
	input  wire logic        wdt_en_i,
	output logic             wdt_clear_o,
	output logic             slow_rc_en_o,
	// System clock control.
	input  wire logic        sys_osc_ready_i,
	output logic             sys_osc_on_o,
	output logic             sysclk_en_o,
	output logic [2:0]       sysclk_sel_o,
	output logic             osc_switch_o,
	output logic             fscm_en_o,
	output logic             periph_clk_en_o,
	output logic             chg_det_en_o,
	// Secondary oscillator.
	input  wire logic [1:0]  sec_osc_req_i,
	output logic             sec_osc_en_o,
	output logic             sec_osc_ready_o,
	output logic             sec_osc_low_drive_o,
	output logic             sec_osc_digital_o
);

	localparam int NSYNC = 5;

	////////////////////////////////////////////////////////////////////////////
	// Synchronise every input that arrives from outside this clock.
	logic [NSYNC-1:0] raw_async;
	logic [NSYNC-1:0] syn;
	logic             irq_s;
	logic             wdt_to_s;
	logic             osc_rdy_s;
	logic [1:0]       sec_req_s;

	assign raw_async = {sec_osc_req_i, sys_osc_ready_i, wdt_timeout_i, irq_wake_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			psc_sync3 u_sync (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.async_i (raw_async[gi]),
				.sync_o  (syn[gi])
			);
		end
	endgenerate

	assign irq_s     = syn[0];
	assign wdt_to_s  = syn[1];
	assign osc_rdy_s = syn[2];
	assign sec_req_s = syn[4:3];

	// True when a bus address selects the given register.
	function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
		return adr == off;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and software registers.
	logic        ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic        manual_q, manual_d;
	logic        lock_q, lock_d;
	logic        pinsel_q, pinsel_d;
	logic        drive_q, drive_d;
	logic [2:0]  cur_osc_q, cur_osc_d;
	logic        switch_q, switch_d;
	logic        wr_byte0;
	psc_state_t  st_q, st_d;
	logic        sec_en_q, sec_rdy_q;
	logic        wdt_wake_q, wdt_wake_d;

	// Answer every access in the cycle after it starts; unmapped reads give zero.
	always_comb begin
		ack_d    = cyc_i && stb_i && !ack_q;
		wr_byte0 = ack_d && we_i && sel_i[0];
		manual_d = manual_q;
		lock_d   = lock_q;
		pinsel_d = pinsel_q;
		drive_d  = drive_q;
		cur_osc_d = cur_osc_q;
		switch_d = 1'b0;
		if (wr_byte0 && hit(adr_i, ADR_CTRL)) begin
			manual_d = dat_i[CTRL_MANUAL_BIT];
			if (!lock_q && dat_i[CTRL_SRC_SEL_LSB +: 3] != cur_osc_q) begin
				cur_osc_d = dat_i[CTRL_SRC_SEL_LSB +: 3];
				switch_d  = 1'b1;
			end
		end
		if (wr_byte0 && hit(adr_i, ADR_OSC_CFG)) begin
			lock_d   = dat_i[OSC_CFG_LOCK_BIT];
			pinsel_d = dat_i[OSC_CFG_PINSEL_BIT];
		end
		if (wr_byte0 && hit(adr_i, ADR_DEV_OPT)) begin
			drive_d = dat_i[DEV_OPT_DRIVE_BIT];
		end
		dat_d = 32'h0;
		if (ack_d && !we_i) begin
			if (hit(adr_i, ADR_CTRL)) begin
				dat_d[CTRL_MANUAL_BIT]       = manual_q;
				dat_d[CTRL_SRC_SEL_LSB +: 3] = cur_osc_q;
			end
			if (hit(adr_i, ADR_OSC_CFG)) begin
				dat_d[OSC_CFG_LOCK_BIT]      = lock_q;
				dat_d[OSC_CFG_PINSEL_BIT]    = pinsel_q;
			end
			if (hit(adr_i, ADR_DEV_OPT)) begin
				dat_d[DEV_OPT_DRIVE_BIT]     = drive_q;
			end
			if (hit(adr_i, ADR_STATUS)) begin
				dat_d[STAT_STATE_LSB +: 4]   = st_q;
				dat_d[STAT_OSC_LSB +: 3]     = cur_osc_q;
				dat_d[STAT_SEC_ON_BIT]       = sec_en_q;
				dat_d[STAT_SEC_RDY_BIT]      = sec_rdy_q;
				dat_d[STAT_WDT_WAKE_BIT]     = wdt_wake_q;
			end
		end
	end

	// Every register returns to its reset value on any reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q     <= 1'b0;
			dat_q     <= 32'h0;
			manual_q  <= MANUAL_RST;
			lock_q    <= LOCK_RST;
			pinsel_q  <= PINSEL_RST;
			drive_q   <= DRIVE_RST;
			cur_osc_q <= SRC_SEL_RST;
			switch_q  <= 1'b0;
		end else begin
			ack_q     <= ack_d;
			dat_q     <= dat_d;
			manual_q  <= manual_d;
			lock_q    <= lock_d;
			pinsel_q  <= pinsel_d;
			drive_q   <= drive_d;
			cur_osc_q <= cur_osc_d;
			switch_q  <= switch_d;
		end
	end

	assign ack_o        = ack_q;
	assign dat_o        = dat_q;
	assign sysclk_sel_o = cur_osc_q;
	assign osc_switch_o = switch_q;

	////////////////////////////////////////////////////////////////////////////
	// Power state machine and the clock gates it drives.
	logic       wake;
	logic [7:0] settle_q, settle_d;
	logic       restart_q, resume_q, resume_d, wdt_clr_q, wdt_clr_d;
	logic       halt_q, halt_d, osc_on_q, osc_on_d, sclk_q, sclk_d;
	logic       fscm_q, fscm_d, pclk_q, pclk_d, slow_rc_q, slow_rc_d;

	// Global interrupt enable plays no part: any enabled source wakes.
	assign wake = irq_s || wdt_to_s;

	// Next state, the sleep-entry watchdog clear and the wake handshake.
	always_comb begin
		st_d       = st_q;
		settle_d   = settle_q;
		resume_d   = 1'b0;
		wdt_clr_d  = 1'b0;
		wdt_wake_d = wdt_wake_q;
		unique case (st_q)
			ST_RUN: begin
				if (psave_req_i) begin
					if (psave_mode_i == PSAVE_IDLE) begin
						st_d = ST_IDLE;
					end else begin
						st_d      = ST_SLEEP;
						wdt_clr_d = wdt_en_i;
					end
				end
			end
			ST_IDLE: begin
				if (wake) begin
					st_d       = ST_RUN;
					resume_d   = 1'b1;
					wdt_wake_d = wdt_to_s;
				end
			end
			ST_SLEEP: begin
				settle_d = 8'h0;
				if (wake) begin
					st_d       = ST_WAKE;
					wdt_wake_d = wdt_to_s;
				end
			end
			ST_WAKE: begin
				// Hold the CPU until the oscillator has been ready long enough.
				if (!osc_rdy_s) begin
					settle_d = 8'h0;
				end else if (settle_q < 8'(SYS_OSC_SETTLE_CYC)) begin
					settle_d = settle_q + 8'h1;
				end else begin
					st_d     = ST_RUN;
					resume_d = 1'b1;
				end
			end
		endcase
		halt_d   = st_d != ST_RUN;
		pclk_d   = st_d == ST_RUN || st_d == ST_IDLE;
		sclk_d   = st_d == ST_RUN || st_d == ST_IDLE;
		osc_on_d = st_d != ST_SLEEP;
		fscm_d   = st_d == ST_RUN || st_d == ST_IDLE;
		slow_rc_d = st_d != ST_SLEEP || wdt_en_i;
	end

	// Reset bypasses the interrupt path and loads the reset vector directly.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q       <= ST_RUN;
			settle_q   <= 8'h0;
			restart_q  <= 1'b1;
			resume_q   <= 1'b0;
			wdt_clr_q  <= 1'b0;
			wdt_wake_q <= 1'b0;
			halt_q     <= 1'b0;
			pclk_q     <= 1'b1;
			sclk_q     <= 1'b1;
			osc_on_q   <= 1'b1;
			fscm_q     <= 1'b1;
			slow_rc_q  <= 1'b1;
		end else begin
			st_q       <= st_d;
			settle_q   <= settle_d;
			restart_q  <= 1'b0;
			resume_q   <= resume_d;
			wdt_clr_q  <= wdt_clr_d;
			wdt_wake_q <= wdt_wake_d;
			halt_q     <= halt_d;
			pclk_q     <= pclk_d;
			sclk_q     <= sclk_d;
			osc_on_q   <= osc_on_d;
			fscm_q     <= fscm_d;
			slow_rc_q  <= slow_rc_d;
		end
	end

	assign cpu_restart_o   = restart_q;
	assign fetch_addr_o    = RESET_VECTOR;
	assign resume_o        = resume_q;
	assign wdt_clear_o     = wdt_clr_q;
	assign cpu_halt_o      = halt_q;
	assign periph_clk_en_o = pclk_q;
	assign sysclk_en_o     = sclk_q;
	assign sys_osc_on_o    = osc_on_q;
	assign fscm_en_o       = fscm_q;
	assign slow_rc_en_o    = slow_rc_q;

	////////////////////////////////////////////////////////////////////////////
	// Secondary oscillator enable, drive, pin role and start-up timer.
	logic [27:0] sec_cnt_q, sec_cnt_d;
	logic        sec_en_d, sec_rdy_d, low_q, low_d, dig_q, dig_d;

	// The timer reports readiness so requesters can wait out the long start.
	always_comb begin
		sec_en_d  = pinsel_q && (manual_q || (|sec_req_s));
		low_d     = !drive_q;
		dig_d     = !pinsel_q;
		sec_cnt_d = sec_cnt_q;
		sec_rdy_d = 1'b0;
		if (!sec_en_q) begin
			sec_cnt_d = 28'h0;
		end else if (sec_cnt_q < 28'(SEC_START_CYC - 1)) begin
			sec_cnt_d = sec_cnt_q + 28'h1;
		end else begin
			sec_rdy_d = sec_en_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec_en_q  <= 1'b0;
			sec_rdy_q <= 1'b0;
			sec_cnt_q <= 28'h0;
			low_q     <= 1'b0;
			dig_q     <= 1'b0;
		end else begin
			sec_en_q  <= sec_en_d;
			sec_rdy_q <= sec_rdy_d;
			sec_cnt_q <= sec_cnt_d;
			low_q     <= low_d;
			dig_q     <= dig_d;
		end
	end

	assign sec_osc_en_o        = sec_en_q;
	assign sec_osc_ready_o     = sec_rdy_q;
	assign sec_osc_low_drive_o = low_q;
	assign sec_osc_digital_o   = dig_q;
	assign chg_det_en_o        = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the behaviour above.
	property p_reset_vector;
		@(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> cpu_restart_o && fetch_addr_o == RESET_VECTOR;
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("no restart at reset vector");

	property p_restart_direct;
		@(posedge clk_i) disable iff (rst_i) cpu_restart_o |-> st_q == ST_RUN && !resume_o && !cpu_halt_o;
	endproperty
	a_restart_direct: assert property (p_restart_direct) else $error("restart went through wake path");

	property p_auto_start;
		@(posedge clk_i) disable iff (rst_i) (|sec_req_s) && pinsel_q |=> sec_osc_en_o;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("request did not start oscillator");

	property p_manual_start;
		@(posedge clk_i) disable iff (rst_i) manual_q && pinsel_q && !(|sec_req_s) |=> sec_osc_en_o;
	endproperty
	a_manual_start: assert property (p_manual_start) else $error("manual enable ignored");

	property p_pins_digital;
		@(posedge clk_i) disable iff (rst_i) !pinsel_q |=> sec_osc_digital_o && !sec_osc_en_o;
	endproperty
	a_pins_digital: assert property (p_pins_digital) else $error("pins not digital");

	property p_drive;
		@(posedge clk_i) disable iff (rst_i) $changed(drive_q) |=> sec_osc_low_drive_o == !$past(drive_q);
	endproperty
	a_drive: assert property (p_drive) else $error("drive select wrong");

	property p_enter_idle;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_RUN && psave_req_i && psave_mode_i == PSAVE_IDLE
			|=> st_q == ST_IDLE && cpu_halt_o && periph_clk_en_o && sysclk_en_o;
	endproperty
	a_enter_idle: assert property (p_enter_idle) else $error("idle entry wrong");

	property p_sleep_off;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_SLEEP
			|-> !sysclk_en_o && !sys_osc_on_o && !fscm_en_o && !periph_clk_en_o && cpu_halt_o;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("clock alive in sleep");

	property p_slow_rc;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_SLEEP && $past(wdt_en_i) |-> slow_rc_en_o;
	endproperty
	a_slow_rc: assert property (p_slow_rc) else $error("rc clock stopped with watchdog on");

	property p_wdt_clear;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_RUN && psave_req_i && psave_mode_i == PSAVE_SLEEP
			&& wdt_en_i |=> wdt_clear_o && st_q == ST_SLEEP;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

	property p_wake;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_SLEEP && wake
			|=> st_q == ST_WAKE && sys_osc_on_o && cpu_halt_o;
	endproperty
	a_wake: assert property (p_wake) else $error("sleep not left on wake");

	property p_same_clock;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_SLEEP |=> $stable(sysclk_sel_o);
	endproperty
	a_same_clock: assert property (p_same_clock) else $error("clock source changed in sleep");

	property p_switch;
		@(posedge clk_i) disable iff (rst_i) wr_byte0 && hit(adr_i, ADR_CTRL) && !lock_q
			&& dat_i[CTRL_SRC_SEL_LSB +: 3] != cur_osc_q |=> osc_switch_o && sysclk_sel_o == $past(dat_i[6:4]);
	endproperty
	a_switch: assert property (p_switch) else $error("clock switch not requested");

	property p_stable_first;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_WAKE && !osc_rdy_s |=> st_q != ST_RUN;
	endproperty
	a_stable_first: assert property (p_stable_first) else $error("resumed before clock stable");

	property p_idle_resume;
		@(posedge clk_i) disable iff (rst_i) st_q == ST_IDLE && wake |=> resume_o && !cpu_halt_o;
	endproperty
	a_idle_resume: assert property (p_idle_resume) else $error("idle wake did not resume");

endmodule

// >>> test_psc_top.sv
// Self-checking testbench for the power-save and secondary oscillator controller.
`timescale 1ns/10ps
module test_psc_top;
	import psc_pkg::*;
	localparam int SEC = 20;
	typedef struct packed { logic [3:0] adr; logic [31:0] exp; } psc_row_t;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, psave_req_i, psave_mode_i, cpu_restart_o;
	logic        cpu_halt_o, resume_o, irq_wake_i, wdt_timeout_i, wdt_en_i, wdt_clear_o, slow_rc_en_o;
	logic        sys_osc_ready_i, sys_osc_on_o, sysclk_en_o, osc_switch_o, fscm_en_o, periph_clk_en_o;
	logic        chg_det_en_o, sec_osc_en_o, sec_osc_ready_o, sec_osc_low_drive_o, sec_osc_digital_o, sec_use;
	logic [3:0]  adr_i, sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [23:0] fetch_addr_o;
	logic [2:0]  sysclk_sel_o;
	logic [1:0]  sec_osc_req_i, want;
	logic [7:0]  dly;
	int          mismatches, cmp_count, cycles, sw_cnt, clr_cnt, res_cnt, n, ne, c;
	psc_row_t    rows [5];

	psc_top #(.SEC_START_CYC(SEC)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.psave_req_i(psave_req_i), .psave_mode_i(psave_mode_i), .cpu_restart_o(cpu_restart_o),
		.fetch_addr_o(fetch_addr_o), .cpu_halt_o(cpu_halt_o), .resume_o(resume_o), .irq_wake_i(irq_wake_i),
		.wdt_timeout_i(wdt_timeout_i), .wdt_en_i(wdt_en_i), .wdt_clear_o(wdt_clear_o), .slow_rc_en_o(slow_rc_en_o),
		.sys_osc_ready_i(sys_osc_ready_i), .sys_osc_on_o(sys_osc_on_o), .sysclk_en_o(sysclk_en_o),
		.sysclk_sel_o(sysclk_sel_o), .osc_switch_o(osc_switch_o), .fscm_en_o(fscm_en_o),
		.periph_clk_en_o(periph_clk_en_o), .chg_det_en_o(chg_det_en_o), .sec_osc_req_i(sec_osc_req_i),
		.sec_osc_en_o(sec_osc_en_o), .sec_osc_ready_o(sec_osc_ready_o),
		.sec_osc_low_drive_o(sec_osc_low_drive_o), .sec_osc_digital_o(sec_osc_digital_o));

	psc_partner partner (.clk_i(clk_i), .rst_i(rst_i), .osc_on_i(sys_osc_on_o), .dly_i(dly), .want_i(want),
		.sec_rdy_i(sec_osc_ready_o), .osc_ready_o(sys_osc_ready_i), .sec_req_o(sec_osc_req_i),
		.sec_use_o(sec_use));

	////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Counts pulses seen at each rising edge and cuts a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (osc_switch_o === 1'b1) sw_cnt++;
		if (wdt_clear_o === 1'b1) clr_cnt++;
		if (resume_o === 1'b1) res_cnt++;
		if (cycles > 20000) begin
			mismatches++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task results;
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Lets k edges pass and settles just after the last.
	task tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	// One classic Wishbone cycle; holds the request until ack is sampled high.
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= 4'h1;
		adr_i <= a;
		dat_i <= d;
		// Only the bench's cycle ceiling ends a wait that never sees ack.
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	// Power-save instruction pulse with its operand.
	task psave(input logic m);
		@(posedge clk_i);
		psave_req_i  <= 1'b1;
		psave_mode_i <= m;
		@(posedge clk_i);
		psave_req_i  <= 1'b0;
	endtask

	// Waits for the resume pulse; the CPU must stay halted while the oscillator is not ready.
	task wait_res;
		int c0;
		c0 = res_cnt;
		n = 0;
		while (res_cnt == c0 && n < 300) begin
			tick(1);
			n++;
			if (sys_osc_ready_i !== 1'b1 && cpu_halt_o !== 1'b1) chk(cpu_halt_o, 1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{cyc_i, stb_i, we_i, psave_req_i, psave_mode_i, irq_wake_i, wdt_timeout_i, wdt_en_i} = 8'h00;
		{adr_i, dat_i, want, mismatches, cmp_count, cycles, sw_cnt, clr_cnt, res_cnt} = '0;
		sel_i = 4'h1;
		dly   = 8'h02;
		rst_i = 1'b1;
		rows = '{'{ADR_CTRL, 32'h0}, '{ADR_OSC_CFG, 32'h8}, '{ADR_DEV_OPT, 32'h8}, '{ADR_STATUS, 32'h1},
			'{4'h2, 32'h0}};
		tick(20);
		chk(cpu_restart_o, 1);
		chk(fetch_addr_o, 24'h000000);
		@(posedge clk_i) rst_i <= 1'b0;
		tick(3);
		chk({cpu_restart_o, cpu_halt_o, chg_det_en_o, sec_osc_low_drive_o, sec_osc_digital_o}, 5'b00100);
		foreach (rows[i]) begin
			wb(1'b0, rows[i].adr, 32'h0);
			chk(q, rows[i].exp);
		end
		// Clock switch while unlocked, then refused while locked.
		c = sw_cnt;
		wb(1'b1, ADR_CTRL, 32'h50);
		tick(3);
		chk({sysclk_sel_o, 4'(sw_cnt - c)}, {3'h5, 4'h1});
		wb(1'b1, ADR_OSC_CFG, 32'h9);
		wb(1'b1, ADR_CTRL, 32'h20);
		tick(3);
		chk({sysclk_sel_o, 4'(sw_cnt - c)}, {3'h5, 4'h1});
		wb(1'b1, ADR_OSC_CFG, 32'h8);
		// Each module request starts the oscillator on its own; then the manual enable.
		for (int i = 0; i < 3; i++) begin
			if (i < 2) @(posedge clk_i) want <= 2'b01 << i;
			else wb(1'b1, ADR_CTRL, 32'h51);
			ne = 0;
			while (sec_osc_en_o !== 1'b1 && ne < 20) begin tick(1); ne++; end
			n = 0;
			while (sec_osc_ready_o !== 1'b1 && n < 200) begin tick(1); n++; end
			chk(ne <= 6 && n >= SEC - 1 && n <= SEC + 3, 1);
			if (i == 2) @(posedge clk_i) want <= 2'b10;
			tick(1);
			chk(sec_use, 1);
			if (i == 2) begin
				wb(1'b1, ADR_OSC_CFG, 32'h0);
				tick(3);
				chk({sec_osc_en_o, sec_osc_digital_o}, 2'b01);
				wb(1'b1, ADR_OSC_CFG, 32'h8);
				wb(1'b1, ADR_CTRL, 32'h50);
			end
			@(posedge clk_i) want <= 2'b00;
			tick(8);
			chk(sec_osc_en_o, 0);
		end
		wb(1'b1, ADR_DEV_OPT, 32'h0);
		tick(2);
		chk(sec_osc_low_drive_o, 1);
		wb(1'b1, ADR_DEV_OPT, 32'h8);
		tick(2);
		chk(sec_osc_low_drive_o, 0);
		// Idle: CPU halted, peripheral clocks on, wake by an enabled interrupt.
		psave(PSAVE_IDLE);
		tick(2);
		chk({cpu_halt_o, periph_clk_en_o, sysclk_en_o}, 3'b111);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk(q[3:0], 4'h2);
		@(posedge clk_i) irq_wake_i <= 1'b1;
		wait_res();
		chk(n <= 10, 1);
		tick(1);
		chk(cpu_halt_o, 0);
		@(posedge clk_i) irq_wake_i <= 1'b0;
		// Let the synchronised wake level fall before the next power-save request.
		repeat (6) @(posedge clk_i);
		// Sleep with the watchdog on and a slow oscillator, woken by a watchdog time-out.
		wdt_en_i <= 1'b1;
		dly <= 8'd30;
		c = clr_cnt;
		psave(PSAVE_SLEEP);
		tick(2);
		chk({cpu_halt_o, sysclk_en_o, sys_osc_on_o}, 3'b100);
		chk({fscm_en_o, periph_clk_en_o, chg_det_en_o}, 3'b001);
		chk({slow_rc_en_o, 4'(clr_cnt - c)}, {1'b1, 4'h1});
		tick(20);
		chk(cpu_halt_o, 1);
		@(posedge clk_i) wdt_timeout_i <= 1'b1;
		wait_res();
		chk(n > 30 + SYS_OSC_SETTLE_CYC && n < 300, 1);
		chk({sysclk_sel_o, sysclk_en_o}, {3'h5, 1'b1});
		@(posedge clk_i) wdt_timeout_i <= 1'b0;
		wb(1'b0, ADR_STATUS, 32'h0);
		chk({q[9], q[3:0]}, 5'h11);
		// Sleep with the watchdog off, woken by an interrupt.
		wdt_en_i <= 1'b0;
		dly <= 8'd2;
		c = clr_cnt;
		psave(PSAVE_SLEEP);
		tick(2);
		chk({slow_rc_en_o, 4'(clr_cnt - c)}, 5'h0);
		@(posedge clk_i) irq_wake_i <= 1'b1;
		wait_res();
		chk(n < 300, 1);
		@(posedge clk_i) irq_wake_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		// A reset in mid-Sleep ends it and clears the control register.
		psave(PSAVE_SLEEP);
		tick(3);
		@(posedge clk_i) rst_i <= 1'b1;
		tick(2);
		chk({cpu_halt_o, cpu_restart_o}, 2'b01);
		@(posedge clk_i) rst_i <= 1'b0;
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(q, 32'h0);
		chk(sysclk_sel_o, 3'h0);
		results();
	end
endmodule
